// ==== logic/vc_arb_cap_pkg.sv ====
// Register map and field layout of the port VC arbitration capability group
`default_nettype none
package vc_arb_cap_pkg;
   localparam int unsigned ADDR_W            = 14;
   localparam int unsigned DATA_W            = 32;
   // Register indices; byte address is four times the index
   localparam logic [11:0] PORT_VC_CONTROL_IDX = 12'h020c;
   localparam logic [11:0] PORT_VC_STATUS_IDX  = 12'h020e;
   localparam logic [11:0] VC_RES0_CAP_IDX     = 12'h0210;
   localparam logic [31:0] PORT_VC_CONTROL_RST = 32'h0000_0000;
   localparam logic [31:0] PORT_VC_STATUS_RST  = 32'h0000_0000;
   // Field positions
   localparam int unsigned LOAD_VC_ARB_TABLE_BIT  = 0;
   localparam int unsigned VC_ARB_SEL_LSB         = 1;
   localparam int unsigned VC_ARB_SEL_MSB         = 3;
   localparam int unsigned VC_ARB_TABLE_STS_BIT   = 0;
   localparam int unsigned PORT_ARB_CAP_LSB       = 0;
   localparam int unsigned PORT_ARB_CAP_MSB       = 7;
   localparam int unsigned ADV_PKT_SW_BIT         = 14;
   localparam int unsigned REJECT_SNOOP_BIT       = 15;
   localparam int unsigned MAX_TIME_SLOTS_LSB     = 16;
   localparam int unsigned MAX_TIME_SLOTS_MSB     = 22;
   localparam int unsigned PORT_ARB_TBL_OFF_LSB   = 24;
   localparam int unsigned PORT_ARB_TBL_OFF_MSB   = 31;
   // Port arbitration capability bits
   localparam logic [7:0]  ARB_CAP_FIXED_RR       = 8'h01;
   localparam logic [7:0]  ARB_CAP_WRR32          = 8'h02;
   localparam logic [7:0]  ARB_CAP_WRR64          = 8'h04;
   localparam logic [7:0]  ARB_CAP_WRR128         = 8'h08;
   localparam logic [7:0]  ARB_CAP_TBWRR128       = 8'h10;
   localparam logic [7:0]  ARB_CAP_WRR256         = 8'h20;
   localparam logic [7:0]  PORT_ARB_CAP_UP        = 8'h03;
   localparam logic [7:0]  PORT_ARB_CAP_DOWN      = 8'h01;
   localparam logic [6:0]  MAX_TIME_SLOTS_VAL     = 7'h00;
   // Table offset in 16-byte units
   localparam logic [7:0]  PORT_ARB_TBL_OFF_UP    = 8'h02;
   localparam logic [7:0]  PORT_ARB_TBL_OFF_DOWN  = 8'h00;
   // Avalon response codes
   localparam logic [1:0]  RESP_OKAY              = 2'h0;
   localparam logic [1:0]  RESP_SLVERR            = 2'h2;
endpackage
`default_nettype wire

// ==== logic/vc_arbitration_capability_regs.sv ====
// Read-only port VC control, status and VC resource 0 capability registers
`default_nettype none
module vc_arbitration_capability_regs
#(
   parameter bit UPSTREAM_PORT = 1'b1
) (
   input  wire logic                              ref_clk_in,
   input  wire logic                              srst_in,
   input  wire logic [vc_arb_cap_pkg::ADDR_W-1:0] avs_address_in,
   input  wire logic                              avs_read_in,
   input  wire logic                              avs_write_in,
   input  wire logic [vc_arb_cap_pkg::DATA_W-1:0] avs_writedata_in,
   input  wire logic [3:0]                        avs_byteenable_in,
   output logic      [vc_arb_cap_pkg::DATA_W-1:0] avs_readdata_out,
   output logic      [1:0]                        avs_response_out,
   output logic                                   avs_waitrequest_out
);
   import vc_arb_cap_pkg::*;

   logic [31:0] readdata_q;
   logic [1:0]  response_q;
   logic        ack_q;
   logic        req;
   logic [11:0] idx;
   logic        take;
   logic [32:0] dec;

   // Port VC control word; no table to load
   function automatic logic [31:0] ctl_word();
      logic [31:0] w;
      logic        load_vc_arb_table;
      logic [2:0]  vc_arb_scheme_select;
      w                    = PORT_VC_CONTROL_RST;
      load_vc_arb_table    = 1'b0;
      vc_arb_scheme_select = 3'h0;
      w[LOAD_VC_ARB_TABLE_BIT]         = load_vc_arb_table;
      w[VC_ARB_SEL_MSB:VC_ARB_SEL_LSB] = vc_arb_scheme_select;
      return w;
   endfunction

   // Port VC status word; only the default VC exists
   function automatic logic [31:0] sts_word();
      logic [31:0] w;
      logic        vc_arb_table_status;
      w                       = PORT_VC_STATUS_RST;
      vc_arb_table_status     = 1'b0;
      w[VC_ARB_TABLE_STS_BIT] = vc_arb_table_status;
      return w;
   endfunction

   // Capability word from the port role
   function automatic logic [31:0] cap_word(input bit up);
      logic [31:0] w;
      logic [7:0]  port_arb_capability;
      logic        adv_packet_switching;
      logic        reject_snoop;
      logic [6:0]  max_time_slots;
      logic [7:0]  port_arb_table_offset;
      w                     = 32'h0000_0000;
      port_arb_capability   = up ? PORT_ARB_CAP_UP : PORT_ARB_CAP_DOWN;
      adv_packet_switching  = 1'b0;
      reject_snoop          = 1'b0;
      max_time_slots        = MAX_TIME_SLOTS_VAL;
      port_arb_table_offset = up ? PORT_ARB_TBL_OFF_UP : PORT_ARB_TBL_OFF_DOWN;
      w[PORT_ARB_CAP_MSB:PORT_ARB_CAP_LSB]         = port_arb_capability;
      w[ADV_PKT_SW_BIT]                            = adv_packet_switching;
      w[REJECT_SNOOP_BIT]                          = reject_snoop;
      w[MAX_TIME_SLOTS_MSB:MAX_TIME_SLOTS_LSB]     = max_time_slots;
      w[PORT_ARB_TBL_OFF_MSB:PORT_ARB_TBL_OFF_LSB] = port_arb_table_offset;
      return w;
   endfunction

   // Register read decode
   function automatic logic [32:0] decode(input logic [11:0] i, input bit up);
      logic [32:0] r;
      r = {1'b0, 32'h0000_0000};
      case (i)
         PORT_VC_CONTROL_IDX: r = {1'b1, ctl_word()};
         PORT_VC_STATUS_IDX:  r = {1'b1, sts_word()};
         VC_RES0_CAP_IDX:     r = {1'b1, cap_word(up)};
         default:             r = {1'b0, 32'h0000_0000};
      endcase
      return r;
   endfunction

   assign idx  = avs_address_in[13:2];
   assign req  = avs_read_in | avs_write_in;
   assign take = req & ~ack_q;
   assign dec  = decode(idx, UPSTREAM_PORT);

   // One wait cycle per access
   assign avs_waitrequest_out = take;
   assign avs_readdata_out    = readdata_q;
   assign avs_response_out    = response_q;

   // Answer flag, high in the cycle that ends the wait
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= take;
      end
   end

   // Response code of the access being answered
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         response_q <= RESP_OKAY;
      end else if (take) begin
         response_q <= dec[32] ? RESP_OKAY : RESP_SLVERR;
      end
   end

   // Read data; a write never reaches this register
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         readdata_q <= 32'h0000_0000;
      end else if (take && avs_read_in) begin
         readdata_q <= dec[31:0];
      end
   end

   // Checks
   logic rd_done;
   assign rd_done = avs_read_in & ack_q;

   chk_ctl_load_bit: assert property (@(posedge ref_clk_in) disable iff (srst_in)
      rd_done && idx == PORT_VC_CONTROL_IDX |-> avs_readdata_out[LOAD_VC_ARB_TABLE_BIT] == 1'b0)
      else $error("load table bit read nonzero");
   chk_ctl_sel_zero: assert property (@(posedge ref_clk_in) disable iff (srst_in)
      rd_done && idx == PORT_VC_CONTROL_IDX |->
      avs_readdata_out[VC_ARB_SEL_MSB:VC_ARB_SEL_LSB] == 3'h0 && avs_readdata_out == 32'h0)
      else $error("vc arb select read nonzero");
   chk_sts_zero: assert property (@(posedge ref_clk_in) disable iff (srst_in)
      rd_done && idx == PORT_VC_STATUS_IDX |-> avs_readdata_out == 32'h0000_0000)
      else $error("vc status read nonzero");
   chk_cap_arb_bits: assert property (@(posedge ref_clk_in) disable iff (srst_in)
      rd_done && idx == VC_RES0_CAP_IDX |->
      (avs_readdata_out[7:0] & (ARB_CAP_WRR64 | ARB_CAP_WRR128 | ARB_CAP_TBWRR128
         | ARB_CAP_WRR256 | 8'hc0)) == 8'h00 && avs_readdata_out[0] == ARB_CAP_FIXED_RR[0])
      else $error("unsupported arbitration scheme reported");
   chk_cap_arb_role: assert property (@(posedge ref_clk_in) disable iff (srst_in)
      rd_done && idx == VC_RES0_CAP_IDX |->
      avs_readdata_out[7:0] == (UPSTREAM_PORT ? 8'h03 : 8'h01))
      else $error("port arbitration capability wrong");
   chk_cap_feature_bits: assert property (@(posedge ref_clk_in) disable iff (srst_in)
      rd_done && idx == VC_RES0_CAP_IDX |-> avs_readdata_out[15:8] == 8'h00)
      else $error("packet switching or snoop bit set");
   chk_cap_slots: assert property (@(posedge ref_clk_in) disable iff (srst_in)
      rd_done && idx == VC_RES0_CAP_IDX |-> avs_readdata_out[23:16] == 8'h00)
      else $error("max time slots nonzero");
   chk_cap_tbl_off: assert property (@(posedge ref_clk_in) disable iff (srst_in)
      rd_done && idx == VC_RES0_CAP_IDX |->
      avs_readdata_out[31:24] == (UPSTREAM_PORT ? 8'h02 : 8'h00))
      else $error("port arbitration table offset wrong");
   chk_write_ignored: assert property (@(posedge ref_clk_in) disable iff (srst_in)
      avs_write_in && !avs_read_in && !ack_q |=> $stable(avs_readdata_out))
      else $error("write changed read data");
   chk_wait_one: assert property (@(posedge ref_clk_in) disable iff (srst_in)
      req && !ack_q ##1 req |-> !avs_waitrequest_out)
      else $error("access not answered after one wait cycle");

   // Bus answer checks, then register content and reset checks
   chk_idle_no_wait: assert property (@(posedge ref_clk_in) disable iff (srst_in)
      !req |-> !avs_waitrequest_out)
      else $error("waitrequest high with no request");
   chk_ack_single: assert property (@(posedge ref_clk_in) disable iff (srst_in)
      ack_q |=> !ack_q)
      else $error("answer flag held two cycles");
   chk_take_answer: assert property (@(posedge ref_clk_in) disable iff (srst_in)
      req && avs_waitrequest_out |=> ack_q)
      else $error("taken access not answered");
   chk_data_hold: assert property (@(posedge ref_clk_in) disable iff (srst_in)
      !avs_waitrequest_out |=> $stable(avs_readdata_out))
      else $error("read data changed without a taken access");
   chk_resp_stable: assert property (@(posedge ref_clk_in) disable iff (srst_in)
      !avs_waitrequest_out |=> $stable(avs_response_out))
      else $error("response changed without a taken access");
   chk_resp_mapped: assert property (@(posedge ref_clk_in) disable iff (srst_in)
      ack_q && (idx == PORT_VC_CONTROL_IDX || idx == PORT_VC_STATUS_IDX
         || idx == VC_RES0_CAP_IDX) |-> avs_response_out == RESP_OKAY)
      else $error("mapped register answered with an error");
   chk_resp_unmapped: assert property (@(posedge ref_clk_in) disable iff (srst_in)
      ack_q && idx != PORT_VC_CONTROL_IDX && idx != PORT_VC_STATUS_IDX
         && idx != VC_RES0_CAP_IDX |-> avs_response_out == RESP_SLVERR)
      else $error("unmapped index answered without an error");
   chk_ctl_reserved: assert property (@(posedge ref_clk_in) disable iff (srst_in)
      rd_done && idx == PORT_VC_CONTROL_IDX |-> avs_readdata_out[31:4] == 28'h000_0000)
      else $error("port VC control reserved bits nonzero");
   chk_sts_status_bit: assert property (@(posedge ref_clk_in) disable iff (srst_in)
      rd_done && idx == PORT_VC_STATUS_IDX |-> avs_readdata_out[VC_ARB_TABLE_STS_BIT] == 1'b0)
      else $error("vc arb table status bit set");
   chk_cap_wrr32_role: assert property (@(posedge ref_clk_in) disable iff (srst_in)
      rd_done && idx == VC_RES0_CAP_IDX |-> avs_readdata_out[1] == UPSTREAM_PORT)
      else $error("32 phase weighted scheme reported for wrong role");
   chk_reset_clears: assert property (@(posedge ref_clk_in)
      srst_in |=> !ack_q && avs_readdata_out == 32'h0000_0000 && avs_response_out == RESP_OKAY)
      else $error("reset left the answer state set");

   cov_read_cap: cover property (@(posedge ref_clk_in) disable iff (srst_in)
      rd_done && idx == VC_RES0_CAP_IDX);
   cov_read_ctl: cover property (@(posedge ref_clk_in) disable iff (srst_in)
      rd_done && idx == PORT_VC_CONTROL_IDX);
   cov_read_sts: cover property (@(posedge ref_clk_in) disable iff (srst_in)
      rd_done && idx == PORT_VC_STATUS_IDX);
   cov_write_any: cover property (@(posedge ref_clk_in) disable iff (srst_in)
      avs_write_in && ack_q);
   cov_unmapped: cover property (@(posedge ref_clk_in) disable iff (srst_in)
      ack_q && avs_response_out == RESP_SLVERR);
endmodule
`default_nettype wire

// ==== tb/vc_arbitration_capability_regs_bench.sv ====
// Self-checking bench for the port VC arbitration capability registers
`default_nettype none
module vc_arbitration_capability_regs_bench
   import vc_arb_cap_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        ref_clk_in = 1'b0;
   logic        srst_in    = 1'b1;
   logic        rd_req     = 1'b0;
   logic        wr_req     = 1'b0;
   logic [13:0] addr       = 14'h0000;
   logic [31:0] wdata      = 32'h0000_0000;
   logic [31:0] rdata_up, rdata_dn, rd_up, rd_dn;
   logic [1:0]  resp, rsp;
   logic [1:0]  resp_dn, rsp_dn;
   logic        wait_up;
   logic        wait_dn;
   int          miscompares = 0;
   int          num_checks  = 0;
   logic [13:0] regs   [3] = '{14'h0830, 14'h0838, 14'h0840};
   logic [31:0] exp_up [3] = '{32'h0000_0000, 32'h0000_0000, 32'h0200_0003};
   logic [31:0] exp_dn [3] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0001};

   always #5 ref_clk_in = ~ref_clk_in;

   vc_arbitration_capability_regs #(.UPSTREAM_PORT(1'b1)) u_dut (
      .ref_clk_in(ref_clk_in), .srst_in(srst_in), .avs_address_in(addr),
      .avs_read_in(rd_req), .avs_write_in(wr_req), .avs_writedata_in(wdata),
      .avs_byteenable_in(4'hf), .avs_readdata_out(rdata_up), .avs_response_out(resp),
      .avs_waitrequest_out(wait_up));
   vc_arbitration_capability_regs #(.UPSTREAM_PORT(1'b0)) u_dut_dn (
      .ref_clk_in(ref_clk_in), .srst_in(srst_in), .avs_address_in(addr),
      .avs_read_in(rd_req), .avs_write_in(wr_req), .avs_writedata_in(wdata),
      .avs_byteenable_in(4'hf), .avs_readdata_out(rdata_dn), .avs_response_out(resp_dn),
      .avs_waitrequest_out(wait_dn));

   task automatic tally_and_finish;
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One bus access, held until waitrequest is sampled low
   task automatic acc(input logic w, input logic [13:0] a, input logic [31:0] d);
      rd_req <= ~w;
      wr_req <= w;
      addr   <= a;
      wdata  <= d;
      do @(posedge ref_clk_in); while (wait_up !== 1'b0 || wait_dn !== 1'b0);
      rd_up  = rdata_up;
      rd_dn  = rdata_dn;
      rsp    = resp;
      rsp_dn = resp_dn;
      rd_req <= 1'b0;
      wr_req <= 1'b0;
      @(posedge ref_clk_in);
   endtask

   initial begin
      repeat (2000) @(posedge ref_clk_in);
      miscompares++;
      tally_and_finish;
   end

   initial begin
      repeat (20) @(posedge ref_clk_in);
      srst_in <= 1'b0;
      @(posedge ref_clk_in);
      // Pass 0 reads reset values, pass 1 rereads after all-ones writes
      for (int p = 0; p < 2; p++) begin
         for (int i = 0; i < 3; i++) begin
            acc(1'b0, regs[i], 32'h0000_0000);
            chk("read up", rd_up, exp_up[i]);
            chk("read downstream", rd_dn, exp_dn[i]);
            chk("read response", {30'h0, rsp}, {30'h0, RESP_OKAY});
            chk("read response dn", {30'h0, rsp_dn}, {30'h0, RESP_OKAY});
            if (i == 2)
               chk("arb cap field", {24'h0, rd_up[7:0]}, 32'h0000_0003);
            acc(1'b1, regs[i], 32'hffff_ffff);
            chk("write response", {30'h0, rsp}, {30'h0, RESP_OKAY});
            chk("write response dn", {30'h0, rsp_dn}, {30'h0, RESP_OKAY});
         end
      end
      acc(1'b0, 14'h0834, 32'h0000_0000);
      chk("unmapped data", rd_up, 32'h0000_0000);
      chk("unmapped response", {30'h0, rsp}, {30'h0, RESP_SLVERR});
      tally_and_finish;
   end
endmodule
`default_nettype wire
